/* core/pthg_pkg.sv */
// Contract
// - test source for total failure at start
// - after total failure, deliver no words
// - block words built from post-failure raw bits
// - online test at start-up and while running
// - withhold output until start-up pass, after defects
// - online test scans raw bits continuously
// - words delivered are 32 bits wide
// - entropy per delivered bit exceeds 0.997
// - output indistinguishable from ideal under procedure A
package pthg_pkg;
	localparam int word_bits = 32;
	localparam int run_bits = 6;
	localparam int win_bits = 10;
	localparam int ones_bits = 11;
	localparam int cnt_bits = 5;
	// repetition cutoff: a stuck source shows as a long run
	localparam logic [5:0] run_cutoff = 6'h20;
	// proportion window and its acceptance band for ones
	localparam logic [9:0] win_last = 10'h3ff;
	localparam logic [10:0] ones_low = 11'h180;
	localparam logic [10:0] ones_high = 11'h280;
	localparam logic [4:0] cnt_last = 5'h1f;

	typedef enum logic [1:0] {
		pthg_idle = 2'b00,
		pthg_startup = 2'b01,
		pthg_run = 2'b10,
		pthg_fail = 2'b11
	} pthg_mode_type;

	typedef struct packed {
		logic last_bit;
		logic first;
		logic [5:0] run;
		logic [9:0] win;
		logic [10:0] ones;
		logic total_fail;
		logic defect;
		logic win_pass;
	} pthg_health_type;

	typedef struct packed {
		pthg_mode_type mode;
		logic [31:0] shift;
		logic [4:0] cnt;
		logic half;
		logic first_half;
		logic [31:0] held;
		logic held_ok;
		logic [31:0] word;
		logic word_valid;
		logic fail_flag;
		logic total_seen;
		logic defect_seen;
		logic startup_done;
	} pthg_main_type;
endpackage : pthg_pkg

/* core/pthg_health_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pthg_health_if;
	logic enable;
	logic raw_bit;
	logic raw_valid;
	logic total_fail;
	logic defect;
	logic win_pass;
	modport monitor (
		input enable, raw_bit, raw_valid,
		output total_fail, defect, win_pass
	);
	modport control (
		output enable, raw_bit, raw_valid,
		input total_fail, defect, win_pass
	);
endinterface : pthg_health_if
`default_nettype wire

/* core/pthg_health.sv */
`timescale 1ns/1ps
`default_nettype none
module pthg_health (
	// system
	input wire logic clock,
	input wire logic reset,
	// tests towards the gate
	pthg_health_if.monitor hif
);
	pthg_pkg::pthg_health_type st, next_st;
	logic [5:0] run_inc;
	logic [10:0] ones_inc;

	always_comb begin
		next_st = st;
		next_st.total_fail = 1'b0;
		next_st.defect = 1'b0;
		next_st.win_pass = 1'b0;
		run_inc = st.run + 6'h01;
		ones_inc = st.ones + {10'h000, hif.raw_bit};
		if (!hif.enable) begin
			next_st.first = 1'b1;
			next_st.run = 6'h00;
			next_st.win = 10'h000;
			next_st.ones = 11'h000;
		end else if (hif.raw_valid) begin
			// every raw bit is checked, none on request only
			next_st.last_bit = hif.raw_bit;
			next_st.first = 1'b0;
			if (st.first || hif.raw_bit != st.last_bit) begin
				next_st.run = 6'h01;
			end else begin
				next_st.run = run_inc;
				if (run_inc == pthg_pkg::run_cutoff) begin
					next_st.total_fail = 1'b1;
					next_st.run = 6'h00;
				end
			end
			if (st.win == pthg_pkg::win_last) begin
				next_st.win = 10'h000;
				next_st.ones = 11'h000;
				if (ones_inc < pthg_pkg::ones_low ||
						ones_inc > pthg_pkg::ones_high) begin
					next_st.defect = 1'b1;
				end else begin
					next_st.win_pass = 1'b1;
				end
			end else begin
				next_st.win = st.win + 10'h001;
				next_st.ones = ones_inc;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			st <= '{first: 1'b1, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign hif.total_fail = st.total_fail;
	assign hif.defect = st.defect;
	assign hif.win_pass = st.win_pass;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_stuck_detect: assert property (
		hif.enable && hif.raw_valid && !st.first &&
		hif.raw_bit == st.last_bit && st.run == 6'h1f
		|=> hif.total_fail)
		else $error("stuck source not flagged");
	a_window_verdict: assert property (
		hif.enable && hif.raw_valid && st.win == 10'h3ff
		|=> (hif.win_pass ^ hif.defect))
		else $error("window ended without verdict");
	a_no_early_verdict: assert property (
		hif.enable && !(hif.raw_valid && st.win == 10'h3ff)
		|=> !hif.win_pass && !hif.defect)
		else $error("verdict outside window end");
	c_window_pass: cover property (hif.win_pass);
endmodule : pthg_health
`default_nettype wire

/* core/pthg_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module pthg_gate (
	// system
	input wire logic clock,
	input wire logic reset,
	// control
	input wire logic start,
	// raw entropy source
	input wire logic raw_bit,
	input wire logic raw_valid,
	// random words to the reader
	output logic [31:0] word,
	output logic word_valid,
	input wire logic word_ready,
	// health status
	output logic fail_flag,
	output logic total_seen,
	output logic defect_seen,
	output logic startup_done
);
	pthg_pkg::pthg_main_type st, next_st;
	pthg_health_if hif ();
	logic bad;
	logic [31:0] next_shift;
	logic out_bit;

	assign hif.enable = st.mode == pthg_pkg::pthg_startup ||
		st.mode == pthg_pkg::pthg_run;
	assign hif.raw_bit = raw_bit;
	assign hif.raw_valid = raw_valid;

	pthg_health u_health (
		.clock(clock),
		.reset(reset),
		.hif(hif)
	);

	assign bad = hif.total_fail || hif.defect;

	always_comb begin
		next_st = st;
		// xor of two raw bits lifts the entropy of each kept bit
		out_bit = st.first_half ^ raw_bit;
		next_shift = {st.shift[30:0], out_bit};
		if (st.word_valid && word_ready) begin
			next_st.word_valid = 1'b0;
		end
		case (st.mode)
			pthg_pkg::pthg_idle: begin
				if (start) begin
					next_st.mode = pthg_pkg::pthg_startup;
				end
			end
			pthg_pkg::pthg_startup: begin
				// bits seen during start-up are never delivered
				if (hif.win_pass) begin
					next_st.mode = pthg_pkg::pthg_run;
					next_st.startup_done = 1'b1;
					next_st.cnt = 5'h00;
					next_st.half = 1'b0;
				end
			end
			pthg_pkg::pthg_run: begin
				if (raw_valid) begin
					next_st.half = !st.half;
					if (!st.half) begin
						next_st.first_half = raw_bit;
					end else begin
						next_st.shift = next_shift;
						next_st.cnt = st.cnt + 5'h01;
						if (st.cnt == pthg_pkg::cnt_last) begin
							// a word is only released one word later,
							// so a stuck run inside it is caught first
							if (st.held_ok && !next_st.word_valid) begin
								next_st.word = st.held;
								next_st.word_valid = 1'b1;
							end
							next_st.held = next_shift;
							next_st.held_ok = 1'b1;
						end
					end
				end
			end
			pthg_pkg::pthg_fail: begin
				next_st.word_valid = 1'b0;
			end
			default: begin
				next_st.mode = pthg_pkg::pthg_fail;
			end
		endcase
		// failure beats the mode change and the offered word, not startup_done; only reset leaves the fail mode
		if (bad && hif.enable) begin
			next_st.mode = pthg_pkg::pthg_fail;
			next_st.word_valid = 1'b0;
			next_st.held_ok = 1'b0;
		end
		// a second verdict can land in the first fail cycle; record it too
		if (bad) begin
			next_st.fail_flag = 1'b1;
			next_st.total_seen = st.total_seen || hif.total_fail;
			next_st.defect_seen = st.defect_seen || hif.defect;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			st <= '{mode: pthg_pkg::pthg_idle, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign word = st.word;
	assign word_valid = st.word_valid;
	assign fail_flag = st.fail_flag;
	assign total_seen = st.total_seen;
	assign defect_seen = st.defect_seen;
	assign startup_done = st.startup_done;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_fail_silences_output: assert property (
		fail_flag |-> !word_valid)
		else $error("word offered after failure");
	a_stuck_blocks_held: assert property (
		hif.total_fail && hif.enable
		|=> fail_flag && !word_valid && !st.held_ok)
		else $error("held word survived total failure");
	a_defect_stops_run: assert property (
		hif.defect && hif.enable |=> defect_seen && fail_flag)
		else $error("defect not acted on");
	a_startup_withholds: assert property (
		!startup_done |-> !word_valid)
		else $error("word before start-up pass");
	a_startup_passes: assert property (
		st.mode == pthg_pkg::pthg_startup && hif.win_pass && !bad
		|=> startup_done && st.mode == pthg_pkg::pthg_run)
		else $error("start-up pass not taken");
	a_word_holds: assert property (
		word_valid && !word_ready && !bad
		|=> word_valid && $stable(word))
		else $error("offered word changed before taken");
	a_flag_sticky: assert property (
		fail_flag |=> fail_flag [*8])
		else $error("failure flag cleared");
	a_run_needs_pass: assert property (
		$rose(startup_done) |-> $past(hif.win_pass))
		else $error("running without a window pass");

	// idle must neither test nor flag; start alone opens the test
	a_idle_holds: assert property (
		st.mode == pthg_pkg::pthg_idle && !start
		|=> st.mode == pthg_pkg::pthg_idle && !fail_flag)
		else $error("idle left without start");

	a_start_tests: assert property (
		st.mode == pthg_pkg::pthg_idle && start
		|=> st.mode == pthg_pkg::pthg_startup && hif.enable)
		else $error("start did not open the test");

	a_total_recorded: assert property (
		hif.total_fail |=> total_seen && fail_flag)
		else $error("total failure not recorded");

	// only reset leaves fail, so a flaky source cannot sneak back in
	a_fail_is_final: assert property (
		st.mode == pthg_pkg::pthg_fail
		|=> st.mode == pthg_pkg::pthg_fail)
		else $error("fail mode left without reset");

	a_fail_drops_held: assert property (
		st.mode == pthg_pkg::pthg_fail
		|-> !st.held_ok && !word_valid)
		else $error("held word kept in fail mode");

	a_word_from_held: assert property (
		$rose(word_valid)
		|-> $past(st.held_ok) && word == $past(st.held))
		else $error("offered word not the held one");

	// the held word is refilled from the shift register on completion
	a_held_refilled: assert property (
		st.mode == pthg_pkg::pthg_run && raw_valid && st.half &&
		st.cnt == pthg_pkg::cnt_last && !bad
		|=> st.held_ok && st.held == st.shift)
		else $error("finished word not held");

	a_done_sticky: assert property (
		startup_done |=> startup_done)
		else $error("start-up pass forgotten");

	a_words_only_run: assert property (
		word_valid |-> st.mode == pthg_pkg::pthg_run)
		else $error("word offered outside run");

	a_take_clears: assert property (
		word_valid && word_ready &&
		!(raw_valid && st.half && st.cnt == pthg_pkg::cnt_last)
		|=> !word_valid)
		else $error("taken word still offered");

	// words go out msb first: the oldest kept bit ends in bit 31
	a_shift_order: assert property (
		st.mode == pthg_pkg::pthg_run && raw_valid && st.half
		|=> st.shift[31:1] == $past(st.shift[30:0]))
		else $error("shift order broken");

	a_first_half_kept: assert property (
		st.mode == pthg_pkg::pthg_run && raw_valid && !st.half
		|=> st.first_half == $past(raw_bit) && $stable(st.shift))
		else $error("first raw bit of a pair lost");

	a_pair_xor: assert property (
		st.mode == pthg_pkg::pthg_run && raw_valid && st.half
		|=> st.shift[0] == ($past(st.first_half) ^ $past(raw_bit)))
		else $error("kept bit is not the pair xor");

	a_seen_sets_flag: assert property (
		total_seen || defect_seen |-> fail_flag)
		else $error("failure seen but flag low");

	c_word_taken: cover property (word_valid && word_ready);
	c_start_passed: cover property ($rose(startup_done));
	c_stuck_in_run: cover property (
		st.mode == pthg_pkg::pthg_run && hif.total_fail);
	c_defect_startup: cover property (
		st.mode == pthg_pkg::pthg_startup && hif.defect);
endmodule : pthg_gate
`default_nettype wire

/* bench/pthg_reader.sv */
`timescale 1ns/1ps
`default_nettype none
module pthg_reader (
	// system
	input wire logic clock,
	input wire logic reset,
	// word stream
	input wire logic [31:0] word,
	input wire logic word_valid,
	output logic word_ready,
	// stall makes a slow reader
	input wire logic stall
);
	logic [31:0] got[$];
	assign word_ready = ~stall;
	always @(posedge clock) begin
		if (reset) begin
			got.delete();
		end else if (word_valid && word_ready) begin
			got.push_back(word);
		end
	end
endmodule : pthg_reader
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic raw_bit = 1'b0;
	logic raw_valid = 1'b0;
	logic stall = 1'b0;
	logic [31:0] word;
	logic word_valid, word_ready, fail_flag;
	logic total_seen, defect_seen, startup_done;
	int errors = 0;
	int total_checks = 0;
	int n;
	always #5 clock = ~clock;
	pthg_gate dut (.clock(clock), .reset(reset), .start(start),
		.raw_bit(raw_bit), .raw_valid(raw_valid), .word(word),
		.word_valid(word_valid), .word_ready(word_ready),
		.fail_flag(fail_flag), .total_seen(total_seen),
		.defect_seen(defect_seen), .startup_done(startup_done));
	pthg_reader rd (.clock(clock), .reset(reset), .word(word),
		.word_valid(word_valid), .word_ready(word_ready), .stall(stall));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: word %h not %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: flag is %b", $time, got);
		end
	endtask : chk_bit
	task automatic final_report;
		if (errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	task automatic idle(input int c);
		raw_valid = 1'b0;
		repeat (c) @(posedge clock);
		#1;
	endtask : idle
	task automatic send_bit(input logic b);
		raw_valid = 1'b1;
		raw_bit = b;
		@(posedge clock);
		#1;
	endtask : send_bit
	// pairs xor to w, ones kept at half so the window passes
	task automatic send_word(input logic [31:0] w);
		for (int j = 31; j >= 0; j--) begin
			send_bit(j[0]);
			send_bit(w[j] ^ j[0]);
		end
	endtask : send_word
	task automatic restart(input logic go);
		reset = 1'b1;
		start = 1'b0;
		idle(4);
		reset = 1'b0;
		start = go;
		idle(2);
	endtask : restart
	task automatic s_startup;
		restart(1'b1);
		repeat (15) send_word(32'ha55a5aa5);
		chk_bit(word_valid, 1'b0);
		send_word(32'ha55a5aa5);
		idle(2);
		chk_bit(startup_done, 1'b1);
		chk_bit(fail_flag, 1'b0);
	endtask : s_startup
	task automatic s_words;
		stall = 1'b1;
		send_word(32'h5aa5a55a);
		send_word(32'ha5a55a5a);
		idle(3);
		chk_bit(word_valid, 1'b1);
		chk(word, 32'h5aa5a55a);
		stall = 1'b0;
		idle(2);
		chk(rd.got.size(), 32'h1);
		send_word(32'h5a5aa5a5);
		idle(3);
		chk(rd.got[1], 32'ha5a55a5a);
	endtask : s_words
	// stuck run starting late in a word: the older held word still
	// comes out, the word holding stuck bits never does
	task automatic s_stuck;
		n = rd.got.size();
		for (int j = 31; j >= 4; j--) begin
			send_bit(j[0]);
			send_bit(j[0]);
		end
		repeat (32) send_bit(1'b1);
		idle(2);
		chk_bit(total_seen, 1'b1);
		chk_bit(defect_seen, 1'b0);
		chk_bit(word_valid, 1'b0);
		send_word(32'ha55a5aa5);
		send_word(32'ha55a5aa5);
		idle(3);
		chk(rd.got.size(), n + 1);
		chk(rd.got[n], 32'h5a5aa5a5);
	endtask : s_stuck
	task automatic s_defect(input logic in_run);
		restart(1'b1);
		if (in_run) begin
			repeat (16) send_word(32'ha55a5aa5);
			idle(3);
		end
		repeat (256) begin
			send_bit(1'b1);
			send_bit(1'b1);
			send_bit(1'b1);
			send_bit(1'b0);
		end
		idle(4);
		chk_bit(defect_seen, 1'b1);
		chk_bit(fail_flag, 1'b1);
		chk_bit(word_valid, 1'b0);
		chk_bit(startup_done, in_run);
	endtask : s_defect
	initial begin
		restart(1'b0);
		repeat (40) send_bit(1'b0);
		idle(2);
		chk_bit(total_seen, 1'b0);
		s_startup();
		s_words();
		s_stuck();
		restart(1'b1);
		repeat (32) send_bit(1'b0);
		idle(2);
		chk_bit(total_seen, 1'b1);
		chk_bit(startup_done, 1'b0);
		s_defect(1'b0);
		s_defect(1'b1);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
